/* hdl/slt_pkg.sv */
/*
 * Shared constants for the serial lane output stage: register map, field
 * positions, reset values, lane geometry, test-select codes and PRBS taps.
 * Assumes one core clock and an APB master with 32-bit data.
 */
// How it works
// (R1) 9-bit 64B/66B format, 8 or 4 lanes
// (R2) channel A: nine bits msb first, three zeros
// (R3) dual parts: lanes 4-7 carry channel B
// (R4) sync header scheme: detection or correction
// (R5) detection is CRC-12 only, no CRC-3
// (R6) alternative scheme is forward error correction
// (R7) redundant lanes only for four-lane formats
// (R8) lane set 0 uses lanes 0-3, 1 uses 4-7
// (R9) only one lane set drives at once
// (R10) power-down pin or mode bit disables drivers
// (R11) configuration survives power-down
// (R12) receiver relinks and discards pipeline flush data
// (R13) test select picks pattern, zero means normal
// (R14) powered lanes follow format in test modes
// (R15) test select changes only while link disabled
// (R16) PRBS bypasses scrambling and line coding
// (R17) PRBS sequences follow the O.150 definitions
// (R18) each lane starts PRBS at distinct phase
// (R19) PRBS7 taps 6 and 7, period 127
// (R20) PRBS9 taps 5 and 9, period 511
// (R21) PRBS15 taps 14 and 15, period 32767
// (R22) PRBS23 taps 18/23, PRBS31 taps 28/31
// (R23) generator steps per bit, never all zero
// (R24) normal mode sends scrambled mapped link data
package slt_pkg;
    localparam logic [11:0] CTRL_OFF      = 12'h000;
    localparam logic [11:0] STAT_OFF      = 12'h004;
    localparam logic [11:0] FCNT_OFF      = 12'h008;
    localparam int          FMT_LSB       = 0;
    localparam int          FMT_W         = 5;
    localparam int          ALT_BIT       = 5;
    localparam int          FEC_BIT       = 6;
    localparam int          PDM_BIT       = 7;
    localparam int          TEST_LSB      = 8;
    localparam int          TEST_W        = 3;
    localparam int          LINK_BIT      = 11;
    localparam int          STAT_PD_BIT   = 8;
    localparam int          STAT_FMT_BIT  = 9;
    localparam logic [31:0] CTRL_RST      = 32'h0000_000f;
    localparam logic [4:0]  FMT_9B_66B    = 5'h0f;
    localparam int          SAMP_W        = 9;
    localparam int          WORD_W        = 12;
    localparam int          LANES         = 8;
    localparam int          SET_LANES     = 4;
    localparam int          FRAME_BITS    = 24;
    localparam logic [2:0]  TST_NONE      = 3'h0;
    localparam logic [2:0]  TST_PRBS7     = 3'h1;
    localparam logic [2:0]  TST_PRBS9     = 3'h2;
    localparam logic [2:0]  TST_PRBS15    = 3'h3;
    localparam logic [2:0]  TST_PRBS23    = 3'h4;
    localparam logic [2:0]  TST_PRBS31    = 3'h5;
    localparam int          PRBS_W        = 31;
    localparam int          SCR_W         = 58;
    localparam int          SCR_TAP       = 39;

    typedef struct packed {
        logic [4:0] near;
        logic [4:0] far;
    } slt_taps_s;

    function automatic slt_taps_s slt_prbs_taps(input logic [2:0] mode);
        slt_taps_s t;
        t = '{near: 5'd6, far: 5'd7};                           // (R19)
        case (mode)
            TST_PRBS9:  t = '{near: 5'd5, far: 5'd9};           // (R20)
            TST_PRBS15: t = '{near: 5'd14, far: 5'd15};         // (R21)
            TST_PRBS23: t = '{near: 5'd18, far: 5'd23};         // (R22)
            TST_PRBS31: t = '{near: 5'd28, far: 5'd31};         // (R22)
            default:    t = '{near: 5'd6, far: 5'd7};
        endcase
        return t;
    endfunction
endpackage

/* hdl/slt_lane_if.sv */
/*
 * Per-lane carrier between the output stage and its pattern generator
 * and scrambler. Assumes the owner drives mode, restart and scr_din.
 */
`timescale 1ns/100ps
interface slt_lane_if;
    logic [2:0] mode;
    logic       restart;
    logic       prbs_bit;
    logic       scr_din;
    logic       scr_dout;
    modport prbs (input mode, input restart, output prbs_bit);
    modport scr  (input scr_din, output scr_dout);
endinterface

/* hdl/slt_prbs.sv */
/*
 * Per-lane PRBS generator, one bit per clock, taps chosen by mode.
 * Assumes restart is pulsed by the owner whenever the mode changes.
 */
`timescale 1ns/100ps
module slt_prbs #(
    parameter logic [slt_pkg::PRBS_W-1:0] SEED = {{(slt_pkg::PRBS_W-1){1'b0}}, 1'b1}
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    slt_lane_if.prbs  lane
);
    import slt_pkg::*;

    typedef struct packed {
        logic [PRBS_W-1:0] sr;
        logic              bit_q;
    } slt_prbs_s;

    slt_prbs_s         st_r;
    slt_prbs_s         st_nxt;
    slt_taps_s         taps;
    logic [PRBS_W-1:0] live;
    logic              fb;

    always_comb begin
        taps   = slt_prbs_taps(lane.mode);
        live   = ~({PRBS_W{1'b1}} << taps.far);
        fb     = st_r.sr[taps.near - 5'd1] ^ st_r.sr[taps.far - 5'd1];   // (R17)
        st_nxt = st_r;
        // sr[k-1] holds the bit sent k positions earlier
        if (lane.restart || (st_r.sr & live) == '0) begin
            st_nxt.sr = SEED;                                   // (R23)
        end else begin
            st_nxt.sr = {st_r.sr[PRBS_W-2:0], fb};              // (R23)
        end
        st_nxt.bit_q = fb;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= '{sr: SEED, bit_q: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lane.prbs_bit = st_r.bit_q;

    prbs7_law_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // (R19)
        (lane.mode == TST_PRBS7 && !lane.restart) [*8] |=>
        lane.prbs_bit == ($past(lane.prbs_bit, 6) ^ $past(lane.prbs_bit, 7)))
        else $error("prbs7 bit does not follow taps 6 and 7");
    // a switch to a shorter pattern can meet a zero window only in its restart cycle
    prbs_nonzero_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // (R23)
        !lane.restart |-> (st_r.sr & live) != '0)
        else $error("prbs generator reached the all-zero state");
endmodule

/* hdl/slt_scram.sv */
/*
 * Per-lane self-synchronous 64B/66B payload scrambler, 1 + x^39 + x^58.
 * Assumes one payload bit per clock; no reseed needed on the far side.
 */
`timescale 1ns/100ps
module slt_scram (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    slt_lane_if.scr   lane
);
    import slt_pkg::*;

    typedef struct packed {
        logic [SCR_W-1:0] sr;
        logic             dout;
        logic [5:0]       age;
    } slt_scr_s;

    slt_scr_s st_r;
    slt_scr_s st_nxt;
    logic     sb;

    always_comb begin
        sb            = lane.scr_din ^ st_r.sr[SCR_TAP-1] ^ st_r.sr[SCR_W-1];
        st_nxt        = st_r;
        st_nxt.sr     = {st_r.sr[SCR_W-2:0], sb};
        st_nxt.dout   = sb;
        // the law check waits until the whole 58-bit history is real
        st_nxt.age    = (st_r.age == 6'h3f) ? st_r.age : st_r.age + 6'h01;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lane.scr_dout = st_r.dout;

    scr_law_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // (R24)
        st_r.age == 6'h3f |->
        lane.scr_dout == ($past(lane.scr_din) ^ $past(lane.scr_dout, 39)
                          ^ $past(lane.scr_dout, 58)))
        else $error("scrambler output breaks the x^39 x^58 law");
endmodule

/* hdl/slt_top.sv */
/*
 * Serial lane output stage for the 9-bit 64B/66B format: sample-to-lane
 * mapping, scrambling, redundant lane sets, power-down gating and PRBS
 * test insertion, with an APB register slave.
 * Assumes APB signals and the power-down pin are synchronous to clk_i and
 * that sync header coding (CRC-12 or FEC) sits downstream of lane_data_o.
 */
`timescale 1ns/100ps
module slt_top #(
    parameter int CHANNELS = 2
) (
    input  wire logic                                clk_i,
    input  wire logic                                resetn_i,
    input  wire logic [11:0]                         paddr_i,
    input  wire logic                                psel_i,
    input  wire logic                                penable_i,
    input  wire logic                                pwrite_i,
    input  wire logic [31:0]                         pwdata_i,
    input  wire logic [3:0]                          pstrb_i,
    output logic      [31:0]                         prdata_o,
    output logic                                     pready_o,
    output logic                                     pslverr_o,
    input  wire logic                                power_down_pin_i,
    input  wire logic [slt_pkg::LANES*slt_pkg::SAMP_W-1:0] samp_a_i,
    input  wire logic [slt_pkg::LANES*slt_pkg::SAMP_W-1:0] samp_b_i,
    output logic                                     frame_take_o,
    output logic      [slt_pkg::LANES-1:0]           lane_data_o,
    output logic      [slt_pkg::LANES-1:0]           lane_drv_en_o,
    output logic                                     sync_fec_o
);
    import slt_pkg::*;

    typedef struct packed {
        logic [31:0]                          ctrl;
        logic [31:0]                          prdata;
        logic                                 pready;
        logic                                 pslverr;
        logic [15:0]                          fcnt;
        logic [4:0]                           bitcnt;
        logic [LANES-1:0][FRAME_BITS-1:0]     word;
        logic                                 take;
        logic [TEST_W-1:0]                    test_q;
        logic                                 restart;
        logic [LANES-1:0]                     data;
        logic [LANES-1:0]                     drv;
        logic                                 fec;
    } slt_top_s;

    slt_top_s         st_r;
    slt_top_s         st_nxt;
    logic [LANES-1:0] prbs_bits;
    logic [LANES-1:0] scr_bits;
    logic             acc;
    logic             pd;
    logic             fmt_ok;
    logic             alt;
    logic [LANES-1:0] mask;
    logic [TEST_W-1:0] test;
    logic             link_en;

    // one 9-bit sample out of a flat bus of eight
    function automatic logic [SAMP_W-1:0] samp(input logic [LANES*SAMP_W-1:0] bus,
                                               input int idx);
        return bus[idx*SAMP_W +: SAMP_W];
    endfunction

    // 12-bit slots: sample msb first, then three zero pad bits
    function automatic logic [FRAME_BITS-1:0] lane_word(
        input logic [LANES*SAMP_W-1:0] a,
        input logic [LANES*SAMP_W-1:0] b,
        input int                      lane,
        input logic                    dual);
        logic [LANES*SAMP_W-1:0] src;
        int                      k;
        src = (dual && lane >= SET_LANES) ? b : a;                           // (R3)
        k   = lane % SET_LANES;
        return {samp(src, k), {(WORD_W-SAMP_W){1'b0}},
                samp(src, k + SET_LANES), {(WORD_W-SAMP_W){1'b0}}};          // (R2)
    endfunction

    // byte-lane merge for APB writes
    function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                               input logic [31:0] wdata,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // unused test codes fall back to normal data
    function automatic logic [TEST_W-1:0] test_code(input logic [TEST_W-1:0] raw);
        return (raw > TST_PRBS31) ? TST_NONE : raw;
    endfunction

    always_comb begin
        acc     = psel_i & penable_i;
        pd      = power_down_pin_i | st_r.ctrl[PDM_BIT];                     // (R10)
        // quad parts cannot carry this format at all
        fmt_ok  = (st_r.ctrl[FMT_LSB +: FMT_W] == FMT_9B_66B) && (CHANNELS != 4); // (R1)
        // eight-lane dual formats have no spare set to fall back to
        alt     = st_r.ctrl[ALT_BIT] && (CHANNELS == 1);                     // (R7)
        link_en = st_r.ctrl[LINK_BIT];
        test    = test_code(st_r.ctrl[TEST_LSB +: TEST_W]);
        if (!fmt_ok) begin
            mask = '0;
        end else if (CHANNELS == 2) begin
            mask = {LANES{1'b1}};                                            // (R1)
        end else if (alt) begin
            mask = {{SET_LANES{1'b1}}, {SET_LANES{1'b0}}};                   // (R8)
        end else begin
            mask = {{SET_LANES{1'b0}}, {SET_LANES{1'b1}}};                   // (R9)
        end

        st_nxt = st_r;

        // apb: one wait state so read data leaves a flip-flop
        st_nxt.pready  = acc & ~st_r.pready;
        st_nxt.pslverr = 1'b0;
        if (acc && !st_r.pready) begin
            st_nxt.pslverr = 1'b0;
            case (paddr_i[11:2])
                CTRL_OFF[11:2]: st_nxt.prdata = st_r.ctrl;
                STAT_OFF[11:2]: st_nxt.prdata = {22'h0, fmt_ok, pd, st_r.drv};
                FCNT_OFF[11:2]: st_nxt.prdata = {16'h0000, st_r.fcnt};
                default: begin
                    st_nxt.prdata  = 32'h0000_0000;
                    st_nxt.pslverr = 1'b1;
                end
            endcase
        end
        if (acc && st_r.pready && pwrite_i && paddr_i[11:2] == CTRL_OFF[11:2]) begin
            // power-down never touches ctrl, so settings survive it
            st_nxt.ctrl = strb_merge(st_r.ctrl, pwdata_i, pstrb_i);          // (R11)
            st_nxt.ctrl[31:LINK_BIT+1] = '0;
            if (link_en) begin
                // pattern may only change while the link is down
                st_nxt.ctrl[TEST_LSB +: TEST_W] = st_r.ctrl[TEST_LSB +: TEST_W]; // (R15)
            end
        end

        // sync header scheme: 0 selects CRC-12, 1 selects FEC; no CRC-3 code
        st_nxt.fec = st_r.ctrl[FEC_BIT];                                     // (R4) (R5) (R6)

        // lane framing: reload every 24 bits, shift msb first
        st_nxt.take = 1'b0;
        if (st_r.bitcnt == 5'(FRAME_BITS - 1)) begin
            st_nxt.bitcnt = '0;
            st_nxt.take   = 1'b1;
            st_nxt.fcnt   = st_r.fcnt + 16'h0001;
            for (int l = 0; l < LANES; l++) begin
                st_nxt.word[l] = lane_word(samp_a_i, samp_b_i, l, CHANNELS == 2); // (R2) (R3)
            end
        end else begin
            st_nxt.bitcnt = st_r.bitcnt + 5'd1;
            for (int l = 0; l < LANES; l++) begin
                st_nxt.word[l] = {st_r.word[l][FRAME_BITS-2:0], 1'b0};
            end
        end

        st_nxt.test_q  = test;
        st_nxt.restart = (test != st_r.test_q);

        // lane count follows the format whatever the pattern
        st_nxt.drv = pd ? '0 : mask;                                         // (R14) (R10)
        for (int l = 0; l < LANES; l++) begin
            if (pd || !mask[l]) begin
                st_nxt.data[l] = 1'b0;
            end else if (st_r.test_q != TST_NONE) begin
                st_nxt.data[l] = prbs_bits[l];                               // (R13) (R16)
            end else begin
                st_nxt.data[l] = link_en & scr_bits[l];                      // (R24)
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r        <= '0;
            st_r.ctrl   <= CTRL_RST;
            st_r.restart <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        slt_lane_if lane_if ();
        assign lane_if.mode    = st_r.test_q;
        assign lane_if.restart = st_r.restart;
        assign lane_if.scr_din = st_r.word[l][FRAME_BITS-1];
        assign prbs_bits[l]    = lane_if.prbs_bit;
        assign scr_bits[l]     = lane_if.scr_dout;

        slt_prbs #(
            .SEED (PRBS_W'(l + 1))                                           // (R18)
        ) u_prbs (
            .clk_i    (clk_i),
            .resetn_i (resetn_i),
            .lane     (lane_if.prbs)
        );

        slt_scram u_scram (
            .clk_i    (clk_i),
            .resetn_i (resetn_i),
            .lane     (lane_if.scr)
        );
    end

    assign prdata_o      = st_r.prdata;
    assign pready_o      = st_r.pready;
    assign pslverr_o     = st_r.pslverr;
    assign frame_take_o  = st_r.take;
    assign lane_data_o   = st_r.data;
    assign lane_drv_en_o = st_r.drv;
    assign sync_fec_o    = st_r.fec;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    apb_answer_a: assert property (
        (acc && !pready_o) |=> pready_o ##1 !pready_o)
        else $error("apb answer not one cycle after access");
    fmt_gate_a: assert property (                                            // (R1)
        st_r.ctrl[FMT_LSB +: FMT_W] != FMT_9B_66B |=> lane_drv_en_o == '0)
        else $error("lanes driven in an unsupported format");
    lane_a_map_a: assert property (                                          // (R2)
        $rose(frame_take_o) |-> st_r.word[0] ==
        {$past(samp_a_i[SAMP_W-1:0]), 3'b000,
         $past(samp_a_i[SET_LANES*SAMP_W +: SAMP_W]), 3'b000})
        else $error("lane 0 word not a0 then a4");
    lane_b_map_a: assert property (                                          // (R3)
        (CHANNELS == 2 && $rose(frame_take_o)) |->
        st_r.word[SET_LANES][FRAME_BITS-1 -: SAMP_W] == $past(samp_b_i[SAMP_W-1:0]))
        else $error("lane 4 does not carry b0 on dual parts");
    fec_select_a: assert property (                                          // (R4)
        ##1 sync_fec_o == $past(st_r.ctrl[FEC_BIT]))
        else $error("sync header scheme does not follow ctrl");
    dual_no_alt_a: assert property (                                         // (R7)
        (CHANNELS == 2 && fmt_ok && !pd) |=> lane_drv_en_o == 8'hff)
        else $error("dual format lanes not all driven");
    alt_route_a: assert property (                                           // (R8)
        (CHANNELS == 1 && fmt_ok && !pd && st_r.ctrl[ALT_BIT]) |=> lane_drv_en_o == 8'hf0)
        else $error("alternate lane set not selected");
    one_set_a: assert property (                                             // (R9)
        CHANNELS == 2 || !(|lane_drv_en_o[3:0] && |lane_drv_en_o[7:4]))
        else $error("both lane sets driven");
    pd_quiet_a: assert property (                                            // (R10)
        power_down_pin_i |=> lane_drv_en_o == '0 && lane_data_o == '0)
        else $error("drivers active during power-down");
    test_hold_a: assert property (                                           // (R15)
        link_en |=> st_r.ctrl[TEST_LSB +: TEST_W] == $past(st_r.ctrl[TEST_LSB +: TEST_W]))
        else $error("test select changed with link enabled");
    prbs_path_a: assert property (                                           // (R16)
        (st_r.test_q != TST_NONE && !pd && mask[0]) |=> lane_data_o[0] == $past(prbs_bits[0]))
        else $error("prbs lane 0 not sent raw");
    normal_path_a: assert property (                                         // (R24)
        (st_r.test_q == TST_NONE && link_en && !pd && mask[1]) |=>
        lane_data_o[1] == $past(scr_bits[1]))
        else $error("normal lane 1 not scrambled data");

    pd_entry_c:  cover property ($rose(power_down_pin_i) ##1 lane_drv_en_o == '0);
    prbs31_c:    cover property (st_r.test_q == TST_PRBS31 && lane_drv_en_o != '0);
    alt_set_c:   cover property (lane_drv_en_o == 8'hf0);
    apb_err_c:   cover property (pready_o && pslverr_o);
endmodule

/* tb/slt_rx_model.sv */
/*
 * Far-side receiver model: descrambles the lanes and checks PRBS streams.
 * Assumes one serial bit per clk_i and test codes from slt_pkg.
 */
`timescale 1ns/100ps
module slt_rx_model
    import slt_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic [7:0]       lane_data_i,
    input  wire logic [7:0]       lane_en_i,
    input  wire logic [2:0]       mode_i,
    input  wire logic             resync_i,
    output logic      [7:0]       descr_o,
    output logic      [7:0][63:0] hist_o,
    output logic      [31:0]      prbs_err_o
);
    logic [5:0] warm_r;
    logic [7:0] bad;
    int         na;
    int         nb;
    always_comb begin
        case (mode_i)
            TST_PRBS7:  begin na = 6;  nb = 7;  end
            TST_PRBS9:  begin na = 5;  nb = 9;  end
            TST_PRBS15: begin na = 14; nb = 15; end
            TST_PRBS23: begin na = 18; nb = 23; end
            TST_PRBS31: begin na = 28; nb = 31; end
            default:    begin na = 0;  nb = 0;  end
        endcase
        for (int l = 0; l < 8; l++) begin
            descr_o[l] = lane_data_i[l] ^ hist_o[l][38] ^ hist_o[l][57];
            bad[l] = (na != 0) && lane_en_i[l] &&
                     (lane_data_i[l] != (hist_o[l][na-1] ^ hist_o[l][nb-1]));
        end
    end
    // self-synchronising: after a resync nothing is judged until history refills
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hist_o <= '0;
            warm_r <= '0;
            prbs_err_o <= '0;
        end else begin
            for (int l = 0; l < 8; l++) hist_o[l] <= {hist_o[l][62:0], lane_data_i[l]};
            warm_r <= resync_i ? 6'h00 : (warm_r == 6'h3f ? warm_r : warm_r + 6'h01);
            if (warm_r > 6'h28) prbs_err_o <= prbs_err_o + 32'($countones(bad));
        end
    end
endmodule

/* tb/tb.sv */
/*
 * Self-checking bench for slt_top in dual-channel form.
 * Assumes the receiver model sits on the lane outputs.
 */
`timescale 1ns/100ps
module tb;
    import slt_pkg::*;
    logic clk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic power_down_pin_i, frame_take_o, sync_fec_o, resync;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd, seed, prbs_err;
    logic [71:0] samp_a_i, samp_b_i;
    logic [7:0] lane_data_o, lane_drv_en_o, descr, s_drv;
    logic [7:0][63:0] hist;
    logic [23:0] got [8];
    logic er;
    int errors, check_count;

    slt_top #(.CHANNELS(2)) slt_top_inst (.clk_i(clk_i), .resetn_i(resetn_i),
        .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .power_down_pin_i(power_down_pin_i),
        .samp_a_i(samp_a_i), .samp_b_i(samp_b_i), .frame_take_o(frame_take_o),
        .lane_data_o(lane_data_o), .lane_drv_en_o(lane_drv_en_o), .sync_fec_o(sync_fec_o));
    slt_rx_model slt_rx_model_inst (.clk_i(clk_i), .resetn_i(resetn_i),
        .lane_data_i(lane_data_o), .lane_en_i(lane_drv_en_o), .mode_i(rd[10:8]),
        .resync_i(resync), .descr_o(descr), .hist_o(hist), .prbs_err_o(prbs_err));
    // single-channel copy on the same bus: the only form where lane set select acts
    if (1) begin : g_single
        slt_top #(.CHANNELS(1)) slt_top_inst (.clk_i(clk_i), .resetn_i(resetn_i),
            .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
            .pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(), .pready_o(), .pslverr_o(),
            .power_down_pin_i(power_down_pin_i), .samp_a_i(samp_a_i), .samp_b_i(samp_b_i),
            .frame_take_o(), .lane_data_o(), .lane_drv_en_o(s_drv), .sync_fec_o());
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // lane word: sample k then k+4, each nine bits msb first and three zeros
    function automatic logic [23:0] lane_word(input logic [71:0] a, b, input int l);
        logic [71:0] s;
        s = (l < 4) ? a : b;
        return {s[9*(l%4)+:9], 3'h0, s[9*(l%4+4)+:9], 3'h0};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (pready_o === 1'b1) break;
        end
        if (n == 20) begin
            chk(0, 1, "apb timeout");
            finish_test();
        end
        if (!wr) rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        int n;
        logic [159:0] rnd;
        {resetn_i, psel_i, penable_i, pwrite_i, power_down_pin_i, resync} = '0;
        paddr_i = '0;
        pwdata_i = '0;
        rd = '0;
        seed = 32'h7bff;
        samp_a_i = '0;
        samp_b_i = '0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        apb(0, CTRL_OFF, 0);
        chk(rd, CTRL_RST, "ctrl reset");
        apb(0, 12'h0fc, 0);
        chk({31'h0, er}, 1, "unmapped err");
        for (int r = 0; r < 3; r++) begin
            for (int w = 0; w < 5; w++) begin
                seed = xs(seed);
                rnd[w*32+:32] = seed;
            end
            // corner case: full-scale channel A samples
            if (r == 2) rnd[71:0] = '1;
            samp_a_i <= rnd[71:0];
            samp_b_i <= rnd[143:72];
            apb(1, CTRL_OFF, 32'h0000_080f);
            wait_cyc(100);
            for (n = 0; n < 30 && frame_take_o !== 1'b1; n++) wait_cyc(1);
            if (n == 30) begin
                chk(0, 1, "no frame");
                finish_test();
            end
            wait_cyc(2);
            for (int b = 23; b >= 0; b--) begin
                for (int l = 0; l < 8; l++) got[l][b] = descr[l];
                wait_cyc(1);
            end
            for (int l = 0; l < 8; l++)
                chk(got[l], lane_word(samp_a_i, samp_b_i, l), "lane word");
        end
        apb(1, CTRL_OFF, 32'h0000_090f);
        apb(0, CTRL_OFF, 0);
        chk(rd, 32'h0000_080f, "test locked");
        apb(1, CTRL_OFF, 32'h0000_000f);
        for (int m = 1; m < 6; m++) begin
            // select changes only with the link disabled
            // the model restarts its warm-up count while the pattern switches over
            resync <= 1'b1;
            apb(1, CTRL_OFF, 32'h0000_000f | (m << 8));
            apb(0, CTRL_OFF, 0);
            resync <= 1'b0;
            wait_cyc(300);
            chk(prbs_err, 0, "prbs stream");
            chk({31'h0, hist[0][30:0] != hist[1][30:0]}, 1, "lane phase");
            chk({31'h0, hist[7][30:0] != 31'h0}, 1, "nonzero");
            chk(lane_drv_en_o, 8'hff, "test lanes");
        end
        apb(1, CTRL_OFF, 32'h0000_004f);
        wait_cyc(2);
        chk(sync_fec_o, 1, "fec");
        apb(1, CTRL_OFF, 32'h0000_000f);
        wait_cyc(2);
        chk(sync_fec_o, 0, "crc");
        chk(s_drv, 8'h0f, "default lane set");
        power_down_pin_i <= 1'b1;
        wait_cyc(3);
        chk({lane_drv_en_o, lane_data_o}, 0, "pin off");
        apb(0, CTRL_OFF, 0);
        chk(rd, 32'h0000_000f, "ctrl kept");
        power_down_pin_i <= 1'b0;
        apb(1, CTRL_OFF, 32'h0000_008f);
        wait_cyc(3);
        chk(lane_drv_en_o, 0, "mode off");
        apb(0, STAT_OFF, 0);
        chk(rd[9:8], 2'h3, "stat pd fmt");
        apb(1, CTRL_OFF, 32'h0000_002f);
        wait_cyc(3);
        chk(lane_drv_en_o, 8'hff, "dual lanes");
        chk(s_drv, 8'hf0, "alternate lane set");
        finish_test();
    end
endmodule
